// ---- verilog/clock_power_ctrl.sv ----
// Sample clock divider, divider sync, stabiliser lock and power states.
// Assumes sync and pin inputs are synchronous to sys_clk and a
// byte-wide register port from the serial interface.
`default_nettype none
// How it works
// RULE_01: Divide input clock by one to eight
// RULE_02: Sync mode: every pulse or first after write
// RULE_03: Accepted sync resets divider count
// RULE_04: Stabiliser gives nominal half-period high time
// RULE_05: Stabiliser unusable below twenty megahertz input
// RULE_06: System waits for stabiliser relock after change
// RULE_07: Pin high or register enters power-down
// RULE_08: Drivers high impedance while powered down
// RULE_09: Pin low returns to normal operation
// RULE_10: Power-down disables reference, bias and clock
// RULE_11: Wake delay grows with time powered down
// RULE_12: Standby keeps reference powered for faster wake
// RULE_13: Derived clock retimed by its source clock
// RULE_14: Sync sampled, divider reset next edge
module clock_power_ctrl #(
  parameter int RATIO_W = 3,
  parameter int PDT_W = 16,
  parameter int CLK_HZ = clk_pwr_pkg::CLK_HZ
) (
  input wire logic sys_clk, // Undivided sample clock
  input wire logic reset, // Synchronous, active high
  input wire logic sync_in, // Shared divider sync pulse
  input wire logic power_down_pin, // High requests power-down
  input wire logic reg_wr_en, // Register write strobe
  input wire logic reg_rd_en, // Register read strobe
  input wire logic [clk_pwr_pkg::ADDR_W-1:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata_q, // Read data, valid cycle after strobe
  output logic div_clk_q, // Divided internal clock
  output logic conv_tick_q, // One pulse per conversion period
  output clk_pwr_pkg::pwr_ctl_t pwr_q, // Analog enables and driver enable
  output logic wake_ready_q, // Valid operation after wake-up
  output logic dcs_locked_q // Stabiliser loop locked
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam logic DCS_RATE_OK = (CLK_HZ >= clk_pwr_pkg::DCS_MIN_HZ);
  localparam int LOCK_W = $clog2(clk_pwr_pkg::RELOCK_CYC + 1);

  logic [7:0] sync_ctrl_q;
  logic [7:0] dcs_ctrl_q;
  logic [1:0] pmode_q;
  logic [RATIO_W-1:0] ratio_m1_q;
  logic sync_armed_q;
  logic sync_s_q;
  logic sync_prev_q;
  logic sync_accept;
  logic [RATIO_W-1:0] div_count;
  logic [LOCK_W-1:0] lock_cnt_q;
  logic [PDT_W-1:0] pd_time_q;
  logic [PDT_W-1:0] wake_cnt_q;
  clk_pwr_pkg::pwr_state_t state_q;
  clk_pwr_pkg::pwr_state_t state_d;
  logic wr_sync;
  logic wr_div;
  logic wr_dcs;
  logic dcs_on;

  assign wr_sync = reg_wr_en && (reg_addr == clk_pwr_pkg::REG_DIVIDER_SYNC_CONTROL);
  assign wr_div = reg_wr_en && (reg_addr == clk_pwr_pkg::REG_CLOCK_DIVIDE);
  assign wr_dcs = reg_wr_en && (reg_addr == clk_pwr_pkg::REG_DCS_CONTROL);
  assign dcs_on = dcs_ctrl_q[clk_pwr_pkg::DCS_EN_BIT] && DCS_RATE_OK;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_ctrl_q <= clk_pwr_pkg::SYNC_CTRL_RESET;
      dcs_ctrl_q <= clk_pwr_pkg::DCS_CTRL_RESET;
      pmode_q <= clk_pwr_pkg::PMODE_RUN;
      ratio_m1_q <= clk_pwr_pkg::DIV_RATIO_M1_RESET;
    end else if (reg_wr_en) begin
      if (wr_sync) sync_ctrl_q <= reg_wdata;
      if (wr_dcs) dcs_ctrl_q <= reg_wdata;
      if (wr_div) ratio_m1_q <= reg_wdata[RATIO_W-1:0]; // [RULE_01]
      if (reg_addr == clk_pwr_pkg::REG_POWER_MODE) pmode_q <= reg_wdata[1:0]; // [RULE_12]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        clk_pwr_pkg::REG_DIVIDER_SYNC_CONTROL: reg_rdata_q <= sync_ctrl_q;
        clk_pwr_pkg::REG_DCS_CONTROL: reg_rdata_q <= dcs_ctrl_q;
        clk_pwr_pkg::REG_CLOCK_DIVIDE: reg_rdata_q <= 8'(ratio_m1_q);
        clk_pwr_pkg::REG_POWER_MODE: reg_rdata_q <= {6'h00, pmode_q};
        clk_pwr_pkg::REG_STATUS: reg_rdata_q <= {3'h0, sync_armed_q, dcs_locked_q,
                                                 wake_ready_q, state_q};
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Divider sync
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_s_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      sync_s_q <= sync_in; // [RULE_14]
      sync_prev_q <= sync_s_q;
    end
  end

  assign sync_accept = sync_s_q && !sync_prev_q && sync_ctrl_q[clk_pwr_pkg::SYNC_EN_BIT] &&
                       (!sync_ctrl_q[clk_pwr_pkg::SYNC_ONCE_BIT] || sync_armed_q); // [RULE_02]

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_armed_q <= 1'b0;
    end else if (wr_sync) begin
      sync_armed_q <= 1'b1; // A write beats a same-cycle accept [RULE_02]
    end else if (sync_accept) begin
      sync_armed_q <= 1'b0;
    end
  end

  clock_divider #(.RATIO_W(RATIO_W)) u_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(pwr_q.clk_run),
    .realign(sync_accept),
    .dcs_en(dcs_on),
    .ratio_m1(ratio_m1_q),
    .count_q(div_count),
    .tick_q(conv_tick_q),
    .div_clk_q(div_clk_q)
  );

  // ----------------------------------------------------------------
  // Stabiliser lock
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset || !dcs_on || !pwr_q.clk_run || wr_div || wr_dcs) begin
      lock_cnt_q <= LOCK_W'(clk_pwr_pkg::RELOCK_CYC); // [RULE_06]
      dcs_locked_q <= 1'b0; // [RULE_05]
    end else if (lock_cnt_q != '0) begin
      lock_cnt_q <= lock_cnt_q - LOCK_W'(1);
      dcs_locked_q <= 1'b0;
    end else begin
      dcs_locked_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  function automatic logic [PDT_W-1:0] wake_load(input logic [PDT_W-1:0] t, input logic stby);
    logic [PDT_W-1:0] v;
    v = stby ? (t >> clk_pwr_pkg::WAKE_SHIFT_STANDBY) : (t >> clk_pwr_pkg::WAKE_SHIFT_DOWN);
    return (v == '0) ? PDT_W'(1) : v;
  endfunction

  always_comb begin
    state_d = state_q;
    case (state_q)
      clk_pwr_pkg::ST_RUN: begin
        if (power_down_pin || pmode_q == clk_pwr_pkg::PMODE_DOWN) begin
          state_d = clk_pwr_pkg::ST_DOWN; // [RULE_07]
        end else if (pmode_q == clk_pwr_pkg::PMODE_STANDBY) begin
          state_d = clk_pwr_pkg::ST_STANDBY; // [RULE_12]
        end
      end
      clk_pwr_pkg::ST_DOWN, clk_pwr_pkg::ST_STANDBY: begin
        if (power_down_pin || pmode_q == clk_pwr_pkg::PMODE_DOWN) begin
          state_d = clk_pwr_pkg::ST_DOWN;
        end else if (pmode_q == clk_pwr_pkg::PMODE_STANDBY) begin
          state_d = clk_pwr_pkg::ST_STANDBY;
        end else begin
          state_d = clk_pwr_pkg::ST_WAKE; // [RULE_09]
        end
      end
      clk_pwr_pkg::ST_WAKE: begin
        // A new request during wake-up goes straight back down
        if (power_down_pin || pmode_q == clk_pwr_pkg::PMODE_DOWN) begin
          state_d = clk_pwr_pkg::ST_DOWN; // [RULE_07]
        end else if (pmode_q == clk_pwr_pkg::PMODE_STANDBY) begin
          state_d = clk_pwr_pkg::ST_STANDBY; // [RULE_12]
        end else if (wake_cnt_q == PDT_W'(1)) begin
          state_d = clk_pwr_pkg::ST_RUN;
        end
      end
      default: state_d = clk_pwr_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= clk_pwr_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || state_q == clk_pwr_pkg::ST_RUN) begin
      pd_time_q <= '0;
    end else if ((state_q == clk_pwr_pkg::ST_DOWN || state_q == clk_pwr_pkg::ST_STANDBY)
                 && pd_time_q != '1) begin
      pd_time_q <= pd_time_q + PDT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wake_cnt_q <= '0;
    end else if (state_d == clk_pwr_pkg::ST_WAKE && state_q != clk_pwr_pkg::ST_WAKE) begin
      wake_cnt_q <= wake_load(pd_time_q, state_q == clk_pwr_pkg::ST_STANDBY); // [RULE_11]
    end else if (wake_cnt_q != '0) begin
      wake_cnt_q <= wake_cnt_q - PDT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pwr_q <= '{ref_en: 1'b1, ref_buf_en: 1'b1, bias_en: 1'b1, clk_run: 1'b1, drive_en: 1'b1};
      wake_ready_q <= 1'b1;
    end else begin
      pwr_q.ref_en <= (state_d != clk_pwr_pkg::ST_DOWN); // [RULE_10]
      pwr_q.ref_buf_en <= (state_d != clk_pwr_pkg::ST_DOWN); // [RULE_12]
      pwr_q.bias_en <= (state_d == clk_pwr_pkg::ST_RUN || state_d == clk_pwr_pkg::ST_WAKE);
      pwr_q.clk_run <= (state_d == clk_pwr_pkg::ST_RUN || state_d == clk_pwr_pkg::ST_WAKE);
      pwr_q.drive_en <= (state_d == clk_pwr_pkg::ST_RUN || state_d == clk_pwr_pkg::ST_WAKE); // [RULE_08]
      wake_ready_q <= (state_d == clk_pwr_pkg::ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  pin_enters_down_a: assert property (power_down_pin |=> state_q == clk_pwr_pkg::ST_DOWN) else $error("pin high did not power down"); // [RULE_07]
  drivers_off_a: assert property (state_q inside {clk_pwr_pkg::ST_DOWN, clk_pwr_pkg::ST_STANDBY} |-> !pwr_q.drive_en) else $error("driver enabled while down"); // [RULE_08]
  pin_release_a: assert property ($fell(power_down_pin) && pmode_q == clk_pwr_pkg::PMODE_RUN && state_q == clk_pwr_pkg::ST_DOWN |=> state_q == clk_pwr_pkg::ST_WAKE) else $error("pin low did not wake"); // [RULE_09]
  down_blocks_off_a: assert property (state_q == clk_pwr_pkg::ST_DOWN |-> !pwr_q.ref_en && !pwr_q.bias_en && !pwr_q.clk_run) else $error("analog left on in power-down"); // [RULE_10]
  wake_length_a: assert property (state_q == clk_pwr_pkg::ST_DOWN && state_d == clk_pwr_pkg::ST_WAKE |=> wake_cnt_q == wake_load($past(pd_time_q), 1'b0)) else $error("wake delay not from down time"); // [RULE_11]
  standby_ref_a: assert property (state_q == clk_pwr_pkg::ST_STANDBY |-> pwr_q.ref_en && !pwr_q.clk_run) else $error("standby reference state wrong"); // [RULE_12]
  sync_realign_a: assert property (sync_accept |=> div_count == '0) else $error("sync did not reset divider"); // [RULE_03]
  sync_once_a: assert property (sync_accept && sync_ctrl_q[clk_pwr_pkg::SYNC_ONCE_BIT] && !wr_sync |=> !sync_armed_q) else $error("one-shot sync stayed armed"); // [RULE_02]
  ratio_bound_a: assert property (div_count <= ratio_m1_q || $changed(ratio_m1_q)) else $error("divider count past ratio"); // [RULE_01]
  relock_time_a: assert property ($rose(dcs_locked_q) |-> $past(dcs_on, clk_pwr_pkg::RELOCK_CYC)) else $error("lock too early"); // [RULE_05]
  sync_sample_a: assert property ($rose(sync_in) && sync_ctrl_q == 8'h01 ##1 !sync_prev_q |-> sync_accept) else $error("sync not taken next edge"); // [RULE_14]

  cover_sync_c: cover property (sync_accept ##1 conv_tick_q);
  cover_wake_c: cover property (state_q == clk_pwr_pkg::ST_WAKE ##1 state_q == clk_pwr_pkg::ST_RUN);
  cover_standby_c: cover property (state_q == clk_pwr_pkg::ST_STANDBY);
  cover_lock_c: cover property ($rose(dcs_locked_q));
endmodule
`default_nettype wire

// ---- verilog/clk_pwr_pkg.sv ----
// Constants and types shared by the clock divider and power controller.
// Assumes one 20 MHz input clock and a byte-wide serial register port.
`default_nettype none
package clk_pwr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam logic [ADDR_W-1:0] REG_POWER_MODE = 13'h008;
  localparam logic [ADDR_W-1:0] REG_DCS_CONTROL = 13'h009;
  localparam logic [ADDR_W-1:0] REG_CLOCK_DIVIDE = 13'h00B;
  localparam logic [ADDR_W-1:0] REG_STATUS = 13'h00C;
  localparam logic [ADDR_W-1:0] REG_DIVIDER_SYNC_CONTROL = 13'h109;
  localparam int SYNC_EN_BIT = 0;
  localparam int SYNC_ONCE_BIT = 1;
  localparam int DCS_EN_BIT = 0;
  localparam logic [7:0] SYNC_CTRL_RESET = 8'h00;
  localparam logic [7:0] DCS_CTRL_RESET = 8'h01;
  localparam logic [2:0] DIV_RATIO_M1_RESET = 3'h0;
  localparam logic [1:0] PMODE_RUN = 2'h0;
  localparam logic [1:0] PMODE_DOWN = 2'h1;
  localparam logic [1:0] PMODE_STANDBY = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int DCS_MIN_HZ = 20_000_000;
  localparam int RELOCK_MAX_NS = 5000;
  localparam int RELOCK_CYC = RELOCK_MAX_NS / CLK_PERIOD_NS;
  localparam int WAKE_SHIFT_DOWN = 4;
  localparam int WAKE_SHIFT_STANDBY = 6;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_DOWN = 2'h1,
    ST_WAKE = 2'h3,
    ST_STANDBY = 2'h2
  } pwr_state_t;

  typedef struct packed {
    logic ref_en;
    logic ref_buf_en;
    logic bias_en;
    logic clk_run;
    logic drive_en;
  } pwr_ctl_t;
endpackage
`default_nettype wire

// ---- verilog/clock_divider.sv ----
// Integer clock divider with synchronous realign and duty shaping.
// Assumes the realign request is already sampled on sys_clk.
`default_nettype none
module clock_divider #(
  parameter int RATIO_W = 3
) (
  input wire logic sys_clk, // Undivided input clock
  input wire logic reset, // Synchronous, active high
  input wire logic run, // Internal clock allowed to run
  input wire logic realign, // Return count to its initial state
  input wire logic dcs_en, // Regenerate falling edge for half-period high time, rounded up
  input wire logic [RATIO_W-1:0] ratio_m1, // Divide ratio minus one
  output logic [RATIO_W-1:0] count_q, // Current phase count
  output logic tick_q, // One pulse per divided period
  output logic div_clk_q // Retimed divided clock
);
  // Ceiling of half the ratio, in counts
  function automatic logic [RATIO_W:0] half_of(input logic [RATIO_W-1:0] rm1);
    logic [RATIO_W+1:0] r;
    r = {2'b00, rm1} + (RATIO_W+2)'(2);
    return r[RATIO_W+1:1];
  endfunction

  always_ff @(posedge sys_clk) begin
    if (reset || realign || !run) begin
      count_q <= '0; // [RULE_03]
    end else if (count_q >= ratio_m1) begin
      count_q <= '0; // [RULE_01]
    end else begin
      count_q <= count_q + RATIO_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick_q <= 1'b0;
      div_clk_q <= 1'b0;
    end else begin
      tick_q <= run && (count_q == '0);
      // Output comes from a flop on the source clock [RULE_13]
      if (dcs_en) begin
        div_clk_q <= run && ({1'b0, count_q} < half_of(ratio_m1)); // [RULE_04]
      end else begin
        div_clk_q <= run && (count_q == '0);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/sync_source.sv ----
// Partner model: sync pulse source shared by several converters.
// Assumes the bench requests each pulse with a one-cycle fire strobe.
`default_nettype none
module sync_source #(
  parameter int PULSE_W = 2
) (
  input wire logic sys_clk, // Source clock
  input wire logic fire, // Request one pulse
  output logic sync_out // Pulse to the converters
);
  timeunit 1ns;
  timeprecision 1ns;
  int left = 0;
  // Pulse retimed on the source clock, then low so the next edge shows
  always @(posedge sys_clk) begin
    if (fire) left <= PULSE_W;
    else if (left > 0) left <= left - 1;
  end
  assign sync_out = (left > 0);
endmodule
`default_nettype wire

// ---- tb/adc_clock_divider_powerdown_tb.sv ----
// Self-checking bench for the clock divider and power controller.
// Assumes the package, the controller and the sync source compile first.
`default_nettype none
module adc_clock_divider_powerdown_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] val; logic [7:0] mask;} note_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic fire = 1'b0;
  logic power_down_pin = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [clk_pwr_pkg::ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic rd_d1 = 1'b0;
  logic sync_in, div_clk_q, conv_tick_q, wake_ready_q, dcs_locked_q, slow_locked;
  logic [7:0] reg_rdata_q;
  clk_pwr_pkg::pwr_ctl_t pwr_q;
  note_t notes[$];
  note_t n;
  int bad_count = 0;
  int compares = 0;
  int cyc, hi;

  always #25 sys_clk = ~sys_clk;

  clock_power_ctrl #(.PDT_W(16)) dut (.sys_clk(sys_clk), .reset(reset), .sync_in(sync_in),
    .power_down_pin(power_down_pin), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .div_clk_q(div_clk_q), .conv_tick_q(conv_tick_q), .pwr_q(pwr_q),
    .wake_ready_q(wake_ready_q), .dcs_locked_q(dcs_locked_q));
  // Same controller on the same clock, with CLK_HZ set below the stabiliser's floor
  clock_power_ctrl #(.CLK_HZ(10_000_000)) slow (.sys_clk(sys_clk), .reset(reset),
    .sync_in(sync_in), .power_down_pin(power_down_pin), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(),
    .div_clk_q(), .conv_tick_q(), .pwr_q(), .wake_ready_q(), .dcs_locked_q(slow_locked));
  sync_source #(.PULSE_W(2)) src (.sys_clk(sys_clk), .fire(fire), .sync_out(sync_in));

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  always @(posedge sys_clk) rd_d1 <= reg_rd_en;
  always @(negedge sys_clk) begin
    if (rd_d1 === 1'b1) begin
      n = notes.pop_front();
      check(reg_rdata_q & n.mask, n.val, "read data");
    end
  end

  task automatic results();
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [clk_pwr_pkg::ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [clk_pwr_pkg::ADDR_W-1:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    notes.push_back('{e, m});
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
  endtask

  task automatic wait_tick();
    cyc = 0;
    do begin
      @(negedge sys_clk);
      cyc++;
    end while (conv_tick_q !== 1'b1 && cyc < 40);
  endtask

  task automatic period(input int r, input logic duty_cycle_stabiliser);
    wait_tick();
    wait_tick();
    hi = 0;
    cyc = 0;
    do begin
      hi += (div_clk_q === 1'b1);
      @(negedge sys_clk);
      cyc++;
    end while (conv_tick_q !== 1'b1 && cyc < 40);
    check(8'(cyc), 8'(r), "divide ratio");
    check(8'(hi), duty_cycle_stabiliser ? 8'((r + 1) / 2) : 8'h01, "high time");
  endtask

  task automatic sync_try(input logic take);
    wait_tick();
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check({7'h0, conv_tick_q}, {7'h0, take}, "sync realign");
  endtask

  task automatic nap(input logic [7:0] mode, input int t, input int sh, input logic [4:0] off);
    if (mode == 8'h00) begin
      @(posedge sys_clk);
      power_down_pin <= 1'b1;
    end else wr(clk_pwr_pkg::REG_POWER_MODE, mode);
    repeat (t) @(posedge sys_clk);
    @(negedge sys_clk);
    check({3'h0, pwr_q}, {3'h0, off}, "low power enables");
    @(posedge sys_clk);
    power_down_pin <= 1'b0;
    wr(clk_pwr_pkg::REG_POWER_MODE, 8'h00);
    cyc = 0;
    do begin
      @(negedge sys_clk);
      cyc++;
    end while (wake_ready_q !== 1'b1 && cyc < 200);
    check(8'(cyc > (t >> sh) - 2 && cyc < (t >> sh) + 4), 8'h01, "wake time");
    check({3'h0, pwr_q}, 8'h1F, "run enables");
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h0AB5CC3A));
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rd(clk_pwr_pkg::REG_DIVIDER_SYNC_CONTROL, 8'h00, 8'hFF);
    rd(clk_pwr_pkg::REG_DCS_CONTROL, 8'h01, 8'hFF);
    rd(clk_pwr_pkg::REG_CLOCK_DIVIDE, 8'h00, 8'h07);
    rd(clk_pwr_pkg::REG_POWER_MODE, 8'h00, 8'h03);
    wr(13'h1FF, 8'($urandom));
    rd(13'h1FF, 8'h00, 8'hFF);
    wr(clk_pwr_pkg::REG_DIVIDER_SYNC_CONTROL, 8'h03);
    rd(clk_pwr_pkg::REG_DIVIDER_SYNC_CONTROL, 8'h03, 8'hFF);
    for (int d = 0; d < 2; d++) begin
      for (int r = 1; r <= 8; r++) begin
        wr(clk_pwr_pkg::REG_DCS_CONTROL, 8'(d));
        wr(clk_pwr_pkg::REG_CLOCK_DIVIDE, 8'(r - 1));
        period(r, d[0]);
      end
    end
    wr(clk_pwr_pkg::REG_DIVIDER_SYNC_CONTROL, 8'h00);
    sync_try(1'b0);
    wr(clk_pwr_pkg::REG_DIVIDER_SYNC_CONTROL, 8'h01);
    sync_try(1'b1);
    sync_try(1'b1);
    wr(clk_pwr_pkg::REG_DIVIDER_SYNC_CONTROL, 8'h03);
    sync_try(1'b1);
    sync_try(1'b0);
    wr(clk_pwr_pkg::REG_DIVIDER_SYNC_CONTROL, 8'h03);
    sync_try(1'b1);
    wr(clk_pwr_pkg::REG_CLOCK_DIVIDE, 8'h05);
    @(negedge sys_clk);
    check({7'h0, dcs_locked_q}, 8'h00, "lock after change");
    repeat (110) @(posedge sys_clk);
    rd(clk_pwr_pkg::REG_STATUS, 8'h0C, 8'h0F);
    check({7'h0, slow_locked}, 8'h00, "slow clock lock");
    nap(8'h00, 64 + ($urandom % 32), 4, 5'h00);
    nap(8'h00, 192, 4, 5'h00);
    nap(8'h01, 96, 4, 5'h00);
    nap(8'h02, 512, 6, 5'h18);
    @(posedge sys_clk);
    power_down_pin <= 1'b1;
    repeat (160) @(posedge sys_clk);
    power_down_pin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    power_down_pin <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({7'h0, wake_ready_q}, 8'h00, "wake interrupted");
    check({3'h0, pwr_q}, 8'h00, "down from wake");
    @(posedge sys_clk);
    power_down_pin <= 1'b0;
    repeat (40) @(posedge sys_clk);
    @(negedge sys_clk);
    check({7'h0, wake_ready_q}, 8'h01, "wake after second release");
    repeat (3) @(posedge sys_clk);
    results();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
